// file: src/spc_serial_port.sv
// Serial port with clock source selection, break handling, transmit FIFO and error flags.
//
// Function
// - Async code 00: internal baud generator clocks the unit, clock pin not driven.
// - Async code 01: internal generator, clock pin drives a bit-rate clock.
// - Async code 10: clock pin input at sixteen times bit rate; 11 reserved.
// - Sync code 00 drives internal clock out; 10 takes external clock; others reserved.
// - Clock source select is a two-bit field, reset to zero.
// - Software can read the live receive pin level.
// - A frame held all low sets framing error, possibly parity error.
// - Reception continues after a break, so framing error sets again.
// - With transmit disabled, the pin follows port direction and port data.
// - Clearing transmit enable resets the transmitter at once.
// - Sync mode: no transmission starts while any receive error flag is set.
// - Receive enable leaves error flags alone; only explicit clears reset them.
`timescale 1ns/1ps
`include "spc_map.svh"
`default_nettype none

module spc_fifo #(
  parameter int WIDTH = `SPC_FIFO_WIDTH,
  parameter int DEPTH = `SPC_FIFO_DEPTH
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign push       = in_valid_i & in_ready_o;
  assign pop        = out_valid_o & out_ready_i;
  assign out_data_o = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // Ready and valid are registered so the flags never glitch with the pointers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count       <= '0;
      wr_ptr      <= '0;
      rd_ptr      <= '0;
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      count       <= next_count;
      wr_ptr      <= push ? wr_ptr + 1'b1 : wr_ptr;
      rd_ptr      <= pop ? rd_ptr + 1'b1 : rd_ptr;
      in_ready_o  <= next_count != (AW+1)'(DEPTH);
      out_valid_o <= next_count != '0;
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk_i) begin
      if (push && wr_ptr == AW'(i)) begin
        mem[i] <= in_data_i;
      end
    end
  end
endmodule

module spc_serial_port
  import spc_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       sync_mode_i,
  input  wire logic       cfg_we_i,
  input  wire logic [1:0] clock_source_sel_i,
  input  wire logic [1:0] prescale_sel_i,
  input  wire logic [7:0] bit_rate_divisor_i,
  input  wire logic       parity_en_i,
  input  wire logic       parity_odd_i,
  input  wire logic       transmit_enable_bit_i,
  input  wire logic       receive_enable_bit_i,
  input  wire logic       port_direction_register_i,
  input  wire logic       port_data_register_i,
  input  wire logic [2:0] err_clr_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  output logic      [7:0] rx_data_o,
  output logic            rx_valid_o,
  input  wire logic       rx_ready_i,
  input  wire logic       rxd_i,
  output logic            txd_o,
  output logic            txd_oe_o,
  input  wire logic       serial_clock_pin_i,
  output logic            serial_clock_pin_o,
  output logic            serial_clock_pin_oe_o,
  output logic            rxd_level_o,
  output logic            transmit_buffer_empty_flag_o,
  output logic            overrun_error_flag_o,
  output logic            parity_error_flag_o,
  output logic            framing_error_flag_o,
  output logic      [1:0] clock_source_sel_o
);
  logic [1:0]           csel;
  logic [1:0]           presc_sel;
  logic [7:0]           divisor;
  logic [5:0]           presc_cnt;
  logic [5:0]           presc_last;
  logic [7:0]           div_cnt;
  logic                 brg_tick;
  logic [3:0]           clk16_cnt;
  logic                 sck_int;
  logic                 sclk_prev;
  logic                 ext_rise;
  logic                 ext_fall;
  logic                 async_int;
  logic                 async_ext;
  logic                 sync_int;
  logic                 sync_ext;
  logic                 sync_run;
  logic                 tick16;
  logic                 bit_rise;
  logic                 bit_fall;
  logic [`SPC_ERR_W-1:0] err;
  logic [`SPC_ERR_W-1:0] err_set;
  logic [7:0]           fifo_data;
  logic                 fifo_valid;
  logic                 fifo_pop;
  spc_tx_state_t        tx_state;
  logic [7:0]           tx_shift;
  logic [3:0]           tx_bit;
  logic [3:0]           tx_cnt;
  logic                 tx_par;
  logic                 tx_line;
  logic                 tx_step;
  spc_rx_state_t        rx_state;
  logic [7:0]           rx_shift;
  logic [3:0]           rx_bit;
  logic [3:0]           rx_cnt;
  logic                 rx_par;
  logic                 rx_samp;
  logic                 rx_done;
  logic                 rx_bad;

  assign clock_source_sel_o   = csel;
  assign overrun_error_flag_o = err[`SPC_ERR_OVR];
  assign parity_error_flag_o  = err[`SPC_ERR_PAR];
  assign framing_error_flag_o = err[`SPC_ERR_FRM];

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      csel      <= `SPC_CSEL_RESET;
      presc_sel <= `SPC_PRESC_RESET;
      divisor   <= `SPC_DIVISOR_RESET;
    end else if (cfg_we_i) begin
      csel      <= clock_source_sel_i;
      presc_sel <= prescale_sel_i;
      divisor   <= bit_rate_divisor_i;
    end
  end

  // The prescaler divides by 1, 4, 16 or 64 ahead of the divisor counter.
  assign presc_last = 6'((7'h01 << {presc_sel, 1'b0}) - 7'h01);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      presc_cnt <= '0;
      div_cnt   <= '0;
      brg_tick  <= 1'b0;
    end else if (presc_cnt >= presc_last) begin
      // A smaller setting written mid-count takes effect at once instead of after a wrap.
      presc_cnt <= '0;
      brg_tick  <= div_cnt >= divisor;
      div_cnt   <= (div_cnt >= divisor) ? 8'h00 : div_cnt + 8'h01;
    end else begin
      presc_cnt <= presc_cnt + 6'h01;
      brg_tick  <= 1'b0;
    end
  end

  // The clock pin is taken as synchronous, so one stage suffices for edges.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sclk_prev <= 1'b1;
    end else begin
      sclk_prev <= serial_clock_pin_i;
    end
  end

  assign ext_rise  = serial_clock_pin_i & ~sclk_prev;
  assign ext_fall  = ~serial_clock_pin_i & sclk_prev;
  assign async_int = ~sync_mode_i & (csel == `SPC_CSEL_BRG || csel == `SPC_CSEL_BRG_OUT);
  assign async_ext = ~sync_mode_i & (csel == `SPC_CSEL_EXT);
  assign sync_int  = sync_mode_i & (csel == `SPC_CSEL_BRG);
  assign sync_ext  = sync_mode_i & (csel == `SPC_CSEL_EXT);
  assign sync_run  = (tx_state != TX_IDLE) | receive_enable_bit_i;
  // Reserved codes select no clock at all, so the unit simply stalls.
  assign tick16    = async_int ? brg_tick : (async_ext & ext_rise);
  assign bit_rise  = sync_int ? (brg_tick & sync_run & ~sck_int) : (sync_ext & ext_rise);
  assign bit_fall  = sync_int ? (brg_tick & sync_run & sck_int) : (sync_ext & ext_fall);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      clk16_cnt <= '0;
      sck_int   <= 1'b1;
    end else begin
      clk16_cnt <= brg_tick ? clk16_cnt + 4'h1 : clk16_cnt;
      if (!sync_run) begin
        sck_int <= 1'b1;
      end else if (brg_tick) begin
        sck_int <= ~sck_int;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      serial_clock_pin_o    <= 1'b1;
      serial_clock_pin_oe_o <= 1'b0;
    end else begin
      serial_clock_pin_oe_o <= (~sync_mode_i & csel == `SPC_CSEL_BRG_OUT) | sync_int;
      serial_clock_pin_o    <= sync_mode_i ? sck_int : clk16_cnt[3];
    end
  end

  spc_fifo #(
    .WIDTH(`SPC_FIFO_WIDTH),
    .DEPTH(`SPC_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_i      (sys_clk_i),
    .rst_i      (rst_i),
    .in_data_i  (tx_data_i),
    .in_valid_i (tx_valid_i),
    .in_ready_o (tx_ready_o),
    .out_data_o (fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop)
  );

  assign fifo_pop = (tx_state == TX_IDLE) & fifo_valid & transmit_enable_bit_i
                    & ~(sync_mode_i & (|err));
  assign tx_step  = sync_mode_i ? bit_fall : (tick16 & tx_cnt == `SPC_OVS_LAST);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !transmit_enable_bit_i) begin
      tx_state <= TX_IDLE;
      tx_line  <= 1'b1;
      tx_shift <= '0;
      tx_bit   <= '0;
      tx_cnt   <= '0;
      tx_par   <= 1'b0;
    end else begin
      if (tick16) begin
        tx_cnt <= tx_cnt + 4'h1;
      end
      unique case (tx_state)
        TX_IDLE: begin
          if (fifo_pop) begin
            tx_shift <= fifo_data;
            tx_par   <= (^fifo_data) ^ parity_odd_i;
            tx_bit   <= '0;
            tx_cnt   <= '0;
            tx_state <= sync_mode_i ? TX_DATA : TX_START;
            tx_line  <= sync_mode_i;
          end
        end
        TX_START: begin
          if (tx_step) begin
            tx_line  <= tx_shift[0];
            tx_shift <= tx_shift >> 1;
            tx_bit   <= 4'h1;
            tx_state <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_step) begin
            if (tx_bit == `SPC_DATA_BITS) begin
              tx_line  <= sync_mode_i | ~parity_en_i | tx_par;
              tx_state <= sync_mode_i ? TX_IDLE : (parity_en_i ? TX_PAR : TX_STOP);
            end else begin
              tx_line  <= tx_shift[0];
              tx_shift <= tx_shift >> 1;
              tx_bit   <= tx_bit + 4'h1;
            end
          end
        end
        TX_PAR: begin
          if (tx_step) begin
            tx_line  <= 1'b1;
            tx_state <= TX_STOP;
          end
        end
        TX_STOP: begin
          if (tx_step) begin
            tx_state <= TX_IDLE;
          end
        end
      endcase
    end
  end

  // Port control takes the pin whenever transmit is off, which is how mark and break are sent.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      txd_o    <= 1'b1;
      txd_oe_o <= 1'b0;
    end else if (!transmit_enable_bit_i) begin
      txd_o    <= port_data_register_i;
      txd_oe_o <= port_direction_register_i;
    end else begin
      txd_o    <= tx_line;
      txd_oe_o <= 1'b1;
    end
  end

  assign rx_samp = sync_mode_i ? bit_rise : (tick16 & rx_cnt == `SPC_OVS_LAST);
  assign rx_done = rx_samp & ((rx_state == RX_STOP) |
                   (sync_mode_i & rx_state == RX_DATA & rx_bit == `SPC_DATA_LAST));
  // A break reads as all zeros with a low stop bit, so the stop check catches it.
  assign err_set[`SPC_ERR_FRM] = rx_samp & (rx_state == RX_STOP) & ~rxd_i;
  assign err_set[`SPC_ERR_PAR] = rx_samp & (rx_state == RX_PAR) & (rx_par ^ rxd_i ^ parity_odd_i);
  assign err_set[`SPC_ERR_OVR] = rx_done & ~rx_bad & rx_valid_o & ~rx_ready_i;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !receive_enable_bit_i) begin
      rx_state <= RX_IDLE;
      rx_shift <= '0;
      rx_bit   <= '0;
      rx_cnt   <= '0;
      rx_par   <= 1'b0;
      rx_bad   <= 1'b0;
    end else begin
      rx_cnt <= tick16 ? rx_cnt + 4'h1 : rx_cnt;
      unique case (rx_state)
        RX_IDLE: begin
          rx_bit <= '0;
          rx_par <= 1'b0;
          rx_bad <= 1'b0;
          rx_cnt <= '0;
          if (sync_mode_i) begin
            rx_state <= RX_DATA;
          end else if (tick16 && !rxd_i) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (tick16 && rx_cnt == `SPC_OVS_MID) begin
            rx_cnt   <= '0;
            rx_state <= rxd_i ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_samp) begin
            rx_shift <= {rxd_i, rx_shift[7:1]};
            rx_par   <= rx_par ^ rxd_i;
            rx_bit   <= (rx_bit == `SPC_DATA_LAST) ? 4'h0 : rx_bit + 4'h1;
            if (rx_bit == `SPC_DATA_LAST && !sync_mode_i) begin
              rx_state <= parity_en_i ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rx_samp) begin
            rx_bad   <= err_set[`SPC_ERR_PAR];
            rx_state <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_samp) begin
            rx_state <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // Errored frames are not delivered; an unread word is kept and overrun is flagged.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rx_data_o  <= '0;
      rx_valid_o <= 1'b0;
    end else if (rx_done && !rx_bad && !err_set[`SPC_ERR_FRM] && (!rx_valid_o || rx_ready_i)) begin
      rx_data_o  <= sync_mode_i ? {rxd_i, rx_shift[7:1]} : rx_shift;
      rx_valid_o <= 1'b1;
    end else if (rx_ready_i) begin
      rx_valid_o <= 1'b0;
    end
  end

  // Set wins over clear; receive enable has no say over these flags.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      err <= '0;
    end else begin
      err <= (err & ~err_clr_i) | err_set;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rxd_level_o                  <= 1'b1;
      transmit_buffer_empty_flag_o <= 1'b1;
    end else begin
      rxd_level_o                  <= rxd_i;
      transmit_buffer_empty_flag_o <= ~fifo_valid;
    end
  end

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  AST_CSEL_ASYNC00: assert property (!sync_mode_i && csel == `SPC_CSEL_BRG |=> !serial_clock_pin_oe_o)
    else $error("clock pin driven under async code 00");
  AST_CSEL_ASYNC01: assert property (!sync_mode_i && csel == `SPC_CSEL_BRG_OUT |=> serial_clock_pin_oe_o)
    else $error("clock pin not driven under async code 01");
  AST_CSEL_EXT: assert property (csel == `SPC_CSEL_EXT |=> !serial_clock_pin_oe_o)
    else $error("clock pin driven while external clock selected");
  AST_CSEL_SYNC00: assert property (sync_mode_i && csel == `SPC_CSEL_BRG |=> serial_clock_pin_oe_o)
    else $error("sync internal clock not driven out");
  AST_CSEL_RESET: assert property (disable iff (1'b0) rst_i |=> csel == `SPC_CSEL_RESET)
    else $error("clock select not zero after reset");
  AST_RXD_LEVEL: assert property (rxd_level_o == $past(rxd_i))
    else $error("receive pin level not reflected");
  AST_BREAK_FER: assert property (err_set[`SPC_ERR_FRM] |=> framing_error_flag_o)
    else $error("framing error not set on low stop bit");
  AST_FER_SET_WINS: assert property (err_set[`SPC_ERR_FRM] && err_clr_i[`SPC_ERR_FRM] |=> framing_error_flag_o)
    else $error("framing error lost to a simultaneous clear");
  AST_PORT_PIN: assert property (!transmit_enable_bit_i |=> txd_o == $past(port_data_register_i) && txd_oe_o == $past(port_direction_register_i))
    else $error("transmit pin not under port control");
  AST_TE_RESET: assert property (!transmit_enable_bit_i |=> tx_state == TX_IDLE && tx_line && txd_oe_o == $past(port_direction_register_i))
    else $error("transmitter not reset by transmit disable");
  AST_SYNC_ERR_BLOCK: assert property (sync_mode_i && (|err) && tx_state == TX_IDLE |=> tx_state == TX_IDLE)
    else $error("sync transmission started with an error flag set");
  AST_ERR_HOLD: assert property (framing_error_flag_o && !err_clr_i[`SPC_ERR_FRM] |=> framing_error_flag_o)
    else $error("framing error cleared without explicit clear");
  AST_BRG_SPACING: assert property (brg_tick && presc_last == 6'h00 && divisor == 8'h01 && !cfg_we_i |=> !brg_tick ##1 brg_tick)
    else $error("baud tick spacing wrong");

  COV_BREAK: cover property (framing_error_flag_o && parity_error_flag_o && !rxd_level_o);
  COV_TX_DONE: cover property (tx_state == TX_STOP ##1 tx_state == TX_IDLE);
  COV_SYNC_BLOCKED: cover property (sync_mode_i && (|err) && fifo_valid && transmit_enable_bit_i);
  COV_RX_WORD: cover property (rx_valid_o && rx_ready_i);
endmodule

`default_nettype wire

// file: src/spc_map.svh
// Constants for the serial port clock, break and error handling block.
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH

`define SPC_CSEL_BRG       2'h0
`define SPC_CSEL_BRG_OUT   2'h1
`define SPC_CSEL_EXT       2'h2
`define SPC_CSEL_RSVD      2'h3
`define SPC_CSEL_RESET     2'h0
`define SPC_PRESC_RESET    2'h0
`define SPC_DIVISOR_RESET  8'hFF
`define SPC_OVS_LAST       4'hF
`define SPC_OVS_MID        4'h7
`define SPC_DATA_BITS      4'h8
`define SPC_DATA_LAST      4'h7
`define SPC_FIFO_WIDTH     8
`define SPC_FIFO_DEPTH     16
`define SPC_ERR_OVR        0
`define SPC_ERR_PAR        1
`define SPC_ERR_FRM        2
`define SPC_ERR_W          3

`endif

// file: src/spc_pkg.sv
// Types shared by the serial port block.
package spc_pkg;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} spc_tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} spc_rx_state_t;

endpackage

// file: tb/spc_remote.sv
// Remote serial transceiver model on the far side of the transmit and receive lines.
`timescale 1ns/1ps
`default_nettype none

module spc_remote #(
  parameter int BIT_CYC = 64
) (
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      rxd_o
);
  logic [7:0] got [$];

  initial rxd_o = 1'b1;

  // Bytes are sampled mid-bit, LSB first; a start bit gone by mid-bit is ignored as a glitch.
  initial begin : rx_loop
    logic [7:0] b;
    forever begin
      @(negedge clk_i);
      if (line_i === 1'b0) begin
        repeat (BIT_CYC / 2) @(negedge clk_i);
        if (line_i === 1'b0) begin
          for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(negedge clk_i);
            b[i] = line_i;
          end
          repeat (BIT_CYC) @(negedge clk_i);
          got.push_back(b);
        end
      end
    end
  end

  task automatic send_byte(input logic [7:0] b);
    rxd_o = 1'b0;
    repeat (BIT_CYC) @(negedge clk_i);
    for (int i = 0; i < 8; i++) begin
      rxd_o = b[i];
      repeat (BIT_CYC) @(negedge clk_i);
    end
    rxd_o = 1'b1;
    repeat (BIT_CYC) @(negedge clk_i);
  endtask

  task automatic set_line(input logic lvl);
    rxd_o = lvl;
  endtask
endmodule

`default_nettype wire

// file: tb/spc_serial_port_test.sv
// Self-checking bench for the serial port clock, break and error handling block.
`timescale 1ns/1ps
`default_nettype none

module spc_serial_port_test;
  logic       sys_clk, rst, sync_mode, cfg_we, tx_valid, rx_ready, te, re, pdir, pdat;
  logic       ext_run, par_en, par_odd;
  logic [1:0] csel, presc, ext_cnt;
  logic [7:0] div, tx_data;
  logic [2:0] err_clr;
  logic       rxd, tx_ready_o, rx_valid_o, txd_o, txd_oe_o, sclk_o, sclk_oe_o, rxd_level_o;
  logic       empty_o, ovr_o, par_o, frm_o, txd_line;
  logic [7:0] rx_data_o;
  logic [1:0] csel_o;
  int         n_mismatch, checks_done, p;

  // The transmit pin idles high through a pull-up while nobody drives it.
  assign txd_line = txd_oe_o ? txd_o : 1'b1;

  spc_serial_port dut (
    .sys_clk_i(sys_clk), .rst_i(rst), .sync_mode_i(sync_mode), .cfg_we_i(cfg_we),
    .clock_source_sel_i(csel), .prescale_sel_i(presc), .bit_rate_divisor_i(div),
    .parity_en_i(par_en), .parity_odd_i(par_odd), .transmit_enable_bit_i(te),
    .receive_enable_bit_i(re), .port_direction_register_i(pdir),
    .port_data_register_i(pdat), .err_clr_i(err_clr), .tx_data_i(tx_data),
    .tx_valid_i(tx_valid), .tx_ready_o(tx_ready_o), .rx_data_o(rx_data_o),
    .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready), .rxd_i(rxd), .txd_o(txd_o),
    .txd_oe_o(txd_oe_o), .serial_clock_pin_i(~ext_run | ext_cnt[1]), .serial_clock_pin_o(sclk_o),
    .serial_clock_pin_oe_o(sclk_oe_o), .rxd_level_o(rxd_level_o),
    .transmit_buffer_empty_flag_o(empty_o), .overrun_error_flag_o(ovr_o),
    .parity_error_flag_o(par_o), .framing_error_flag_o(frm_o), .clock_source_sel_o(csel_o));

  spc_remote #(.BIT_CYC(64)) rem (.clk_i(sys_clk), .line_i(txd_line), .rxd_o(rxd));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // The outside serial clock rises once every four cycles, idling high while stopped.
  initial begin
    ext_cnt = 2'h0;
    forever @(negedge sys_clk) ext_cnt <= ext_cnt + 2'h1;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      n_mismatch++;
    end
  endtask

  function automatic logic cond(input int s);
    case (s)
      0:       cond = (empty_o === 1'b1);
      1:       cond = (rx_valid_o === 1'b1);
      2:       cond = (frm_o === 1'b1);
      4:       cond = (tx_ready_o === 1'b1);
      default: cond = (rem.got.size() == 16);
    endcase
  endfunction

  task automatic wait_for(input int s, input int lim);
    int k;
    k = 0;
    while (!cond(s)) begin
      @(negedge sys_clk);
      k++;
      if (k > lim) timeout(s);
    end
  endtask

  task automatic timeout(input int s);
    $display("[ERR] wait %0d expected done seen timeout", s);
    n_mismatch++;
    tally_and_finish();
  endtask

  task automatic cfg(input logic s, input logic [1:0] c, input logic [1:0] n, input logic [7:0] d);
    @(negedge sys_clk);
    sync_mode = s;
    csel = c;
    presc = n;
    div = d;
    cfg_we = 1'b1;
    @(negedge sys_clk);
    cfg_we = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic push(input logic [7:0] d);
    @(negedge sys_clk);
    tx_data = d;
    tx_valid = 1'b1;
    wait_for(4, 100);
    @(negedge sys_clk);
    tx_valid = 1'b0;
  endtask

  task automatic rise(output int k);
    k = 0;
    while (sclk_o !== 1'b0) begin
      @(negedge sys_clk);
      k++;
      if (k > 999) timeout(8);
    end
    while (sclk_o !== 1'b1) begin
      @(negedge sys_clk);
      k++;
      if (k > 999) timeout(9);
    end
  endtask

  initial begin
    n_mismatch = 0;
    checks_done = 0;
    rst = 1'b1;
    {sync_mode, cfg_we, tx_valid, rx_ready, te, re, pdir, pdat, ext_run, par_en, par_odd} = 11'h000;
    csel = 2'h0;
    presc = 2'h0;
    div = 8'h03;
    tx_data = 8'h00;
    err_clr = 3'h0;
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    chk("csel reset", {6'h00, csel_o}, 8'h00);
    chk("flags reset", {5'h00, ovr_o, par_o, frm_o}, 8'h00);
    chk("ready empty", {6'h00, tx_ready_o, empty_o}, 8'h03);
    chk("pin enables", {6'h00, txd_oe_o, sclk_oe_o}, 8'h00);
    $display("test reset done");

    // Clock pin direction per mode and source code.
    cfg(1'b0, 2'h0, 2'h0, 8'h03);
    chk("async 00 oe", {7'h00, sclk_oe_o}, 8'h00);
    cfg(1'b0, 2'h1, 2'h0, 8'h03);
    chk("async 01 oe", {7'h00, sclk_oe_o}, 8'h01);
    chk("csel 01", {6'h00, csel_o}, 8'h01);
    rise(p);
    rise(p);
    chk("bit clock 0 3", 8'(p), 8'h40);
    cfg(1'b0, 2'h1, 2'h1, 8'h01);
    rise(p);
    rise(p);
    chk("bit clock 1 1", 8'(p), 8'h80);
    cfg(1'b0, 2'h1, 2'h0, 8'h01);
    rise(p);
    rise(p);
    chk("bit clock 0 1", 8'(p), 8'h20);
    cfg(1'b0, 2'h2, 2'h0, 8'h03);
    chk("async 10 oe", {7'h00, sclk_oe_o}, 8'h00);
    cfg(1'b1, 2'h0, 2'h0, 8'h03);
    chk("sync 00 oe", {7'h00, sclk_oe_o}, 8'h01);
    cfg(1'b1, 2'h2, 2'h0, 8'h03);
    chk("sync 10 oe", {7'h00, sclk_oe_o}, 8'h00);
    chk("csel 10", {6'h00, csel_o}, 8'h02);
    cfg(1'b0, 2'h0, 2'h0, 8'h03);
    $display("test clock source done");

    // Fill the buffer while the transmitter is held off, then drain it onto the line.
    for (int i = 0; i < 16; i++) push(8'(i * 19 + 5));
    chk("fifo full ready", {7'h00, tx_ready_o}, 8'h00);
    chk("line idle", {7'h00, txd_line}, 8'h01);
    te = 1'b1;
    wait_for(3, 14000);
    for (int i = 0; i < 16; i++) chk("tx byte", rem.got[i], 8'(i * 19 + 5));
    wait_for(0, 100);
    re = 1'b1;
    rem.send_byte(8'h3C);
    wait_for(1, 200);
    chk("rx byte", rx_data_o, 8'h3C);
    @(negedge sys_clk);
    rx_ready = 1'b1;
    @(negedge sys_clk);
    rx_ready = 1'b0;
    @(negedge sys_clk);
    chk("rx taken", {7'h00, rx_valid_o}, 8'h00);
    $display("test stream done");

    // Abort a frame into a break, then hold mark, then release the pin.
    pdir = 1'b1;
    pdat = 1'b0;
    push(8'hFF);
    repeat (100) @(negedge sys_clk);
    te = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("break level", {6'h00, txd_oe_o, txd_o}, 8'h02);
    chk("word consumed", {7'h00, empty_o}, 8'h01);
    pdat = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("mark level", {6'h00, txd_oe_o, txd_o}, 8'h03);
    pdir = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("port input", {7'h00, txd_oe_o}, 8'h00);
    $display("test mark break done");

    // A held-low receive line keeps raising the framing flag.
    rem.set_line(1'b0);
    wait_for(2, 2000);
    chk("frame flag", {7'h00, frm_o}, 8'h01);
    chk("rx level", {7'h00, rxd_level_o}, 8'h00);
    err_clr = 3'h4;
    @(negedge sys_clk);
    err_clr = 3'h0;
    @(negedge sys_clk);
    chk("frame cleared", {7'h00, frm_o}, 8'h00);
    wait_for(2, 2000);
    chk("frame again", {7'h00, frm_o}, 8'h01);
    rem.set_line(1'b1);
    re = 1'b0;
    repeat (10) @(negedge sys_clk);
    chk("frame kept", {7'h00, frm_o}, 8'h01);
    chk("rx level high", {7'h00, rxd_level_o}, 8'h01);
    $display("test break done");

    // An outside clock at sixteen times the bit rate times the receiver under odd parity.
    cfg(1'b0, 2'h2, 2'h0, 8'h03);
    ext_run = 1'b1;
    par_en = 1'b1;
    par_odd = 1'b1;
    re = 1'b1;
    rem.send_byte(8'h03);
    repeat (100) @(negedge sys_clk);
    chk("ext clock byte", rx_data_o, 8'h03);
    rem.send_byte(8'h01);
    repeat (100) @(negedge sys_clk);
    chk("parity flag", {7'h00, par_o}, 8'h01);
    rem.send_byte(8'h05);
    repeat (100) @(negedge sys_clk);
    chk("overrun", {5'h00, ovr_o, par_o, rx_valid_o}, 8'h07);
    chk("old word kept", rx_data_o, 8'h03);
    ext_run = 1'b0;
    par_en = 1'b0;
    re = 1'b0;
    $display("test ext clock done");

    // Clocked mode refuses to send while an error flag stands.
    cfg(1'b1, 2'h0, 2'h0, 8'h03);
    te = 1'b1;
    push(8'h5A);
    repeat (300) @(negedge sys_clk);
    chk("held word", {7'h00, empty_o}, 8'h00);
    err_clr = 3'h7;
    @(negedge sys_clk);
    err_clr = 3'h0;
    @(negedge sys_clk);
    chk("flags cleared", {5'h00, ovr_o, par_o, frm_o}, 8'h00);
    wait_for(0, 2000);
    chk("word sent", {7'h00, empty_o}, 8'h01);
    $display("test sync error done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
